// File: hdl/btb_bank.sv
// Beam parameter bank: cyclic beam functions, acyclic teach and blanking parameters.
module btb_bank
  import btb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Beam states from the optical front end, same clock
  input wire logic [NUM_BEAMS-1:0] beam_blocked,
  // Acyclic request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_index,
  input wire logic [31:0] req_wdata,
  // Acyclic response
  output logic resp_valid,
  output logic resp_error,
  output logic [31:0] resp_rdata,
  // Teach-in link to the front end
  output logic fe_teach_start,
  input wire logic fe_teach_done,
  input wire logic [7:0] fe_teach_status,
  input wire logic fe_teach_needed_evt,
  output logic teach_busy,
  // Cyclic beam-function values
  output logic [7:0] interrupted_beam_count,
  output logic [7:0] clear_beam_count,
  output logic [7:0] first_interrupted_beam,
  output logic [7:0] first_clear_beam,
  output logic [7:0] last_interrupted_beam,
  output logic [7:0] last_clear_beam,
  output logic [7:0] consecutive_interrupted_count,
  output logic [7:0] consecutive_clear_count,
  output logic [7:0] central_interrupted_beam,
  output logic [7:0] central_clear_beam,
  output logic [7:0] object_outer_size,
  output logic [7:0] object_inner_size,
  output logic values_updated
);

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================

  // True when an index falls inside the mask word range.
  function automatic logic is_mask_index(input logic [7:0] index);
    is_mask_index = (index >= IDX_MASK_FIRST) && (index <= IDX_MASK_LAST);
  endfunction

  // True when an index names a parameter the master may write.
  function automatic logic is_writable(input logic [7:0] index);
    is_writable = (index == IDX_TEACH_START) || (index == IDX_TEACH_WITH_EXCL) ||
                  (index == IDX_EXCL_INTERRUPTED) || (index == IDX_EXCL_CLEAR);
  endfunction

  // ==========================================================================
  // Parameter state
  // ==========================================================================
  logic teach_start, next_teach_start;
  logic teach_with_exclusion, next_teach_with_exclusion;
  logic exclude_interrupted_beams, next_exclude_interrupted_beams;
  logic exclude_clear_beams, next_exclude_clear_beams;
  logic [NUM_BEAMS-1:0] beam_inclusion_mask, next_beam_inclusion_mask;
  logic next_resp_valid, next_resp_error;
  logic [31:0] next_resp_rdata;

  logic wr, rd, bit_in;
  logic teach_pulse, blank_int_pulse, blank_clr_pulse;
  logic teach_apply;
  logic [7:0] teach_outcome;
  logic teach_needed;
  logic [3:0] word_sel;
  logic [31:0] mask_words [MASK_WORDS];

  // ==========================================================================
  // Mask word view
  // ==========================================================================
  // Word k carries beams 32k+1 .. 32k+32, beam 32k+1 in bit 0.
  genvar gw;
  generate
    for (gw = 0; gw < MASK_WORDS; gw++)
    begin : g_word
      assign mask_words[gw] = beam_inclusion_mask[gw*32 +: 32];
    end
  endgenerate

  // ==========================================================================
  // Request decode
  // ==========================================================================
  always_comb
  begin
    wr = req_valid && req_write;
    rd = req_valid && !req_write;
    bit_in = req_wdata[0];
    word_sel = 4'(req_index - IDX_MASK_FIRST);
    // Triggers fire only when a 1 lands on a parameter that holds 0.
    teach_pulse = wr && (req_index == IDX_TEACH_START) && bit_in && !teach_start;
    blank_int_pulse = wr && (req_index == IDX_EXCL_INTERRUPTED) && bit_in && !exclude_interrupted_beams;
    blank_clr_pulse = wr && (req_index == IDX_EXCL_CLEAR) && bit_in && !exclude_clear_beams;
  end

  // ==========================================================================
  // Writable parameters
  // ==========================================================================
  always_comb
  begin
    next_teach_start = teach_start;
    next_teach_with_exclusion = teach_with_exclusion;
    next_exclude_interrupted_beams = exclude_interrupted_beams;
    next_exclude_clear_beams = exclude_clear_beams;
    if (wr)
    begin
      case (req_index)
        IDX_TEACH_START: next_teach_start = bit_in;
        IDX_TEACH_WITH_EXCL: next_teach_with_exclusion = bit_in;
        IDX_EXCL_INTERRUPTED: next_exclude_interrupted_beams = bit_in;
        IDX_EXCL_CLEAR: next_exclude_clear_beams = bit_in;
        default: next_teach_start = teach_start;
      endcase
    end
  end

  // ==========================================================================
  // Beam inclusion mask
  // ==========================================================================
  // A blanking command replaces the whole mask from the live beam states, so
  // blanking interrupted beams with an empty detection area includes every beam again. A
  // command in the cycle a teach finishes takes precedence.
  always_comb
  begin
    next_beam_inclusion_mask = beam_inclusion_mask;
    if (teach_apply)
    begin
      next_beam_inclusion_mask = ~beam_blocked;
    end
    if (blank_int_pulse)
    begin
      next_beam_inclusion_mask = ~beam_blocked;
    end
    else if (blank_clr_pulse)
    begin
      next_beam_inclusion_mask = beam_blocked;
    end
  end

  // ==========================================================================
  // Response
  // ==========================================================================
  always_comb
  begin
    next_resp_valid = req_valid;
    next_resp_error = 1'b0;
    next_resp_rdata = 32'h0000_0000;
    if (wr && !is_writable(req_index))
    begin
      next_resp_error = 1'b1;
    end
    if (rd)
    begin
      if (is_mask_index(req_index))
      begin
        next_resp_rdata = mask_words[word_sel];
      end
      else
      begin
        case (req_index)
          IDX_TEACH_START: next_resp_rdata = {31'h0, teach_start};
          IDX_TEACH_OUTCOME: next_resp_rdata = {24'h0, teach_outcome};
          IDX_TEACH_NEEDED: next_resp_rdata = {31'h0, teach_needed};
          IDX_TEACH_WITH_EXCL: next_resp_rdata = {31'h0, teach_with_exclusion};
          IDX_EXCL_INTERRUPTED: next_resp_rdata = {31'h0, exclude_interrupted_beams};
          IDX_EXCL_CLEAR: next_resp_rdata = {31'h0, exclude_clear_beams};
          default: next_resp_error = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      teach_start <= RST_CTRL_BIT;
      teach_with_exclusion <= RST_CTRL_BIT;
      exclude_interrupted_beams <= RST_CTRL_BIT;
      exclude_clear_beams <= RST_CTRL_BIT;
      beam_inclusion_mask <= RST_MASK;
      resp_valid <= 1'b0;
      resp_error <= 1'b0;
      resp_rdata <= 32'h0000_0000;
    end
    else
    begin
      teach_start <= next_teach_start;
      teach_with_exclusion <= next_teach_with_exclusion;
      exclude_interrupted_beams <= next_exclude_interrupted_beams;
      exclude_clear_beams <= next_exclude_clear_beams;
      beam_inclusion_mask <= next_beam_inclusion_mask;
      resp_valid <= next_resp_valid;
      resp_error <= next_resp_error;
      resp_rdata <= next_resp_rdata;
    end
  end

  // ==========================================================================
  // Teach-in sequencer
  // ==========================================================================
  btb_teach u_teach (
    .clock(clock),
    .rst_b(rst_b),
    .start_pulse(teach_pulse),
    .with_exclusion(teach_with_exclusion),
    .fe_teach_done(fe_teach_done),
    .fe_teach_status(fe_teach_status),
    .fe_teach_needed_evt(fe_teach_needed_evt),
    .fe_teach_start(fe_teach_start),
    .busy(teach_busy),
    .outcome(teach_outcome),
    .needed(teach_needed),
    .apply_exclusion(teach_apply)
  );

  // ==========================================================================
  // Beam-function scanner
  // ==========================================================================
  btb_scan u_scan (
    .clock(clock),
    .rst_b(rst_b),
    .beam_blocked(beam_blocked),
    .beam_mask(beam_inclusion_mask),
    .interrupted_beam_count(interrupted_beam_count),
    .clear_beam_count(clear_beam_count),
    .first_interrupted_beam(first_interrupted_beam),
    .first_clear_beam(first_clear_beam),
    .last_interrupted_beam(last_interrupted_beam),
    .last_clear_beam(last_clear_beam),
    .consecutive_interrupted_count(consecutive_interrupted_count),
    .consecutive_clear_count(consecutive_clear_count),
    .central_interrupted_beam(central_interrupted_beam),
    .central_clear_beam(central_clear_beam),
    .object_outer_size(object_outer_size),
    .object_inner_size(object_inner_size),
    .scan_done(values_updated)
  );

endmodule

// File: hdl/btb_pkg.sv
// Constants shared by the beam parameter bank and its helpers.
package btb_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int NUM_BEAMS = 512;
  localparam int MASK_WORDS = 16;
  localparam int BEAM_IDX_W = 9;
  localparam int WIDE_W = 10;

  // ==========================================================================
  // Parameter indices
  // ==========================================================================
  localparam logic [7:0] IDX_TEACH_START = 8'h40;
  localparam logic [7:0] IDX_TEACH_OUTCOME = 8'h41;
  localparam logic [7:0] IDX_TEACH_NEEDED = 8'h42;
  localparam logic [7:0] IDX_TEACH_WITH_EXCL = 8'h43;
  localparam logic [7:0] IDX_EXCL_INTERRUPTED = 8'h44;
  localparam logic [7:0] IDX_EXCL_CLEAR = 8'h45;
  localparam logic [7:0] IDX_MASK_FIRST = 8'h46;
  localparam logic [7:0] IDX_MASK_LAST = 8'h55;

  // ==========================================================================
  // Teach outcome bit positions
  // ==========================================================================
  localparam int OUT_GENERAL_ERR = 0;
  localparam int OUT_PARALLEL_ERR = 1;
  localparam int OUT_SIG_LOW_WARN = 2;
  localparam int OUT_SIG_HIGH_WARN = 3;
  localparam int OUT_CROSS_ERR = 4;
  localparam int OUT_FAST_SCAN_WARN = 5;
  localparam int OUT_BLANK_ERR = 6;
  localparam int OUT_AUTO_TEACH_WARN = 7;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic RST_CTRL_BIT = 1'b0;
  localparam logic RST_TEACH_NEEDED = 1'b1;
  localparam logic [7:0] RST_OUTCOME = 8'h00;
  localparam logic [7:0] RST_VALUE8 = 8'h00;
  localparam logic [NUM_BEAMS-1:0] RST_MASK = {NUM_BEAMS{1'b1}};

  typedef enum logic [0:0] {TEACH_IDLE, TEACH_RUN} btb_teach_state_t;

endpackage

// File: hdl/btb_scan.sv
// Beam scanner: walks all beams and derives the cyclic beam-function values.
module btb_scan
  import btb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Beam state
  input wire logic [NUM_BEAMS-1:0] beam_blocked,
  input wire logic [NUM_BEAMS-1:0] beam_mask,
  // Results
  output logic [7:0] interrupted_beam_count,
  output logic [7:0] clear_beam_count,
  output logic [7:0] first_interrupted_beam,
  output logic [7:0] first_clear_beam,
  output logic [7:0] last_interrupted_beam,
  output logic [7:0] last_clear_beam,
  output logic [7:0] consecutive_interrupted_count,
  output logic [7:0] consecutive_clear_count,
  output logic [7:0] central_interrupted_beam,
  output logic [7:0] central_clear_beam,
  output logic [7:0] object_outer_size,
  output logic [7:0] object_inner_size,
  output logic scan_done
);

  // Values wider than a byte saturate rather than wrap.
  function automatic logic [7:0] sat8(input logic [WIDE_W:0] v);
    sat8 = (v > 11'd255) ? 8'hFF : v[7:0];
  endfunction

  // ==========================================================================
  // Accumulators
  // ==========================================================================
  logic [BEAM_IDX_W-1:0] idx, next_idx;
  logic [WIDE_W-1:0] cnt_b, cnt_m, fst_b, fst_m, lst_b, lst_m;
  logic [WIDE_W-1:0] run_b, run_m, max_b, max_m;
  logic [WIDE_W-1:0] a_cnt_b, a_cnt_m, a_fst_b, a_fst_m, a_lst_b, a_lst_m;
  logic [WIDE_W-1:0] a_run_b, a_run_m, a_max_b, a_max_m;
  logic [WIDE_W-1:0] beam_no;
  logic [WIDE_W:0] span;
  logic [WIDE_W:0] cen_b, cen_m;
  logic last;

  always_comb
  begin
    beam_no = WIDE_W'(idx) + 10'd1;
    last = (idx == BEAM_IDX_W'(NUM_BEAMS - 1));
    next_idx = idx + 9'd1;
    a_cnt_b = cnt_b;
    a_cnt_m = cnt_m;
    a_fst_b = fst_b;
    a_fst_m = fst_m;
    a_lst_b = lst_b;
    a_lst_m = lst_m;
    a_run_b = 10'd0;
    a_run_m = 10'd0;
    a_max_b = max_b;
    a_max_m = max_m;
    if (beam_mask[idx])
    begin
      if (beam_blocked[idx])
      begin
        a_cnt_b = cnt_b + 10'd1;
        a_fst_b = (fst_b == 10'd0) ? beam_no : fst_b;
        a_lst_b = beam_no;
        a_run_b = run_b + 10'd1;
        a_max_b = (a_run_b > max_b) ? a_run_b : max_b;
      end
      else
      begin
        a_cnt_m = cnt_m + 10'd1;
        a_fst_m = (fst_m == 10'd0) ? beam_no : fst_m;
        a_lst_m = beam_no;
        a_run_m = run_m + 10'd1;
        a_max_m = (a_run_m > max_m) ? a_run_m : max_m;
      end
    end
    else
    begin
      // An excluded beam is skipped without breaking a run.
      a_run_b = run_b;
      a_run_m = run_m;
    end
    span = (a_fst_b == 10'd0) ? 11'd0 : ({1'b0, a_lst_b} - {1'b0, a_fst_b} + 11'd1);
    cen_b = ({1'b0, a_fst_b} + {1'b0, a_lst_b}) >> 1;
    cen_m = ({1'b0, a_fst_m} + {1'b0, a_lst_m}) >> 1;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idx <= '0;
      {cnt_b, cnt_m, fst_b, fst_m, lst_b, lst_m} <= '0;
      {run_b, run_m, max_b, max_m} <= '0;
      {interrupted_beam_count, clear_beam_count} <= {RST_VALUE8, RST_VALUE8};
      {first_interrupted_beam, first_clear_beam} <= {RST_VALUE8, RST_VALUE8};
      {last_interrupted_beam, last_clear_beam} <= {RST_VALUE8, RST_VALUE8};
      {consecutive_interrupted_count, consecutive_clear_count} <= {RST_VALUE8, RST_VALUE8};
      {central_interrupted_beam, central_clear_beam} <= {RST_VALUE8, RST_VALUE8};
      {object_outer_size, object_inner_size} <= {RST_VALUE8, RST_VALUE8};
      scan_done <= 1'b0;
    end
    else
    begin
      idx <= next_idx;
      scan_done <= last;
      if (last)
      begin
        {cnt_b, cnt_m, fst_b, fst_m, lst_b, lst_m} <= '0;
        {run_b, run_m, max_b, max_m} <= '0;
        interrupted_beam_count <= sat8({1'b0, a_cnt_b});
        clear_beam_count <= sat8({1'b0, a_cnt_m});
        first_interrupted_beam <= sat8({1'b0, a_fst_b});
        first_clear_beam <= sat8({1'b0, a_fst_m});
        last_interrupted_beam <= sat8({1'b0, a_lst_b});
        last_clear_beam <= sat8({1'b0, a_lst_m});
        consecutive_interrupted_count <= sat8({1'b0, a_max_b});
        consecutive_clear_count <= sat8({1'b0, a_max_m});
        central_interrupted_beam <= sat8(cen_b);
        central_clear_beam <= sat8(cen_m);
        object_outer_size <= sat8(span);
        object_inner_size <= sat8(span - {1'b0, a_cnt_b});
      end
      else
      begin
        {cnt_b, cnt_m, fst_b, fst_m, lst_b, lst_m} <= {a_cnt_b, a_cnt_m, a_fst_b, a_fst_m, a_lst_b, a_lst_m};
        {run_b, run_m, max_b, max_m} <= {a_run_b, a_run_m, a_max_b, a_max_m};
      end
    end
  end

endmodule

// File: hdl/btb_teach.sv
// Teach-in sequencer: launches the front end's threshold teach and keeps its outcome.
module btb_teach
  import btb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control from the parameter bank
  input wire logic start_pulse,
  input wire logic with_exclusion,
  // Front end
  input wire logic fe_teach_done,
  input wire logic [7:0] fe_teach_status,
  input wire logic fe_teach_needed_evt,
  output logic fe_teach_start,
  // Results
  output logic busy,
  output logic [7:0] outcome,
  output logic needed,
  output logic apply_exclusion
);

  btb_teach_state_t state, next_state;
  logic next_start, next_apply, next_needed;
  logic [7:0] next_outcome;

  always_comb
  begin
    next_state = state;
    next_start = 1'b0;
    next_apply = 1'b0;
    next_outcome = outcome;
    next_needed = needed;
    case (state)
      TEACH_IDLE:
      begin
        if (start_pulse)
        begin
          next_start = 1'b1;
          next_state = TEACH_RUN;
        end
      end
      TEACH_RUN:
      begin
        if (fe_teach_done)
        begin
          next_outcome = fe_teach_status;
          next_apply = with_exclusion;
          next_needed = fe_teach_status[OUT_GENERAL_ERR];
          next_state = TEACH_IDLE;
        end
      end
      default:
      begin
        next_state = TEACH_IDLE;
      end
    endcase
    // A fresh need raised in the finishing cycle still wins.
    if (fe_teach_needed_evt)
    begin
      next_needed = 1'b1;
    end
  end

  assign busy = (state == TEACH_RUN);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= TEACH_IDLE;
      fe_teach_start <= 1'b0;
      apply_exclusion <= 1'b0;
      outcome <= RST_OUTCOME;
      needed <= RST_TEACH_NEEDED;
    end
    else
    begin
      state <= next_state;
      fe_teach_start <= next_start;
      apply_exclusion <= next_apply;
      outcome <= next_outcome;
      needed <= next_needed;
    end
  end

endmodule

// File: dv/btb_bank_properties.sv
// Concurrent checks on the ports of the beam parameter bank.
module btb_bank_chk
  import btb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Request and response
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_index,
  input wire logic [31:0] req_wdata,
  input wire logic resp_valid,
  input wire logic resp_error,
  // Teach and beam values
  input wire logic fe_teach_start,
  input wire logic teach_busy,
  input wire logic values_updated,
  input wire logic [7:0] interrupted_beam_count,
  input wire logic [7:0] first_interrupted_beam,
  input wire logic [7:0] last_interrupted_beam,
  input wire logic [7:0] consecutive_interrupted_count,
  input wire logic [7:0] central_interrupted_beam
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Assertions and cover properties
  AST_RESP_ONE: assert property (req_valid |=> resp_valid)
    else $error("request without a response one cycle later");
  AST_RESP_ONLY: assert property (!req_valid |=> !resp_valid)
    else $error("response without a request");
  AST_RO_WRITE: assert property (req_valid && req_write && (req_index == IDX_TEACH_OUTCOME
    || req_index == IDX_TEACH_NEEDED) |=> resp_error) else $error("write to a read-only flag accepted");
  AST_MASK_RO: assert property (req_valid && req_write
    && req_index inside {[IDX_MASK_FIRST:IDX_MASK_LAST]} |=> resp_error) else $error("mask write accepted");
  AST_TEACH_CAUSE: assert property (fe_teach_start
    |-> $past(req_valid && req_write && req_index == IDX_TEACH_START && req_wdata[0]))
    else $error("teach start without a write of one");
  AST_TEACH_PULSE: assert property (fe_teach_start |-> teach_busy ##1 !fe_teach_start)
    else $error("teach start not a single pulse with busy");
  AST_UPD_SPACING: assert property (values_updated |=> !values_updated [*8])
    else $error("value update pulses too close");
  AST_RUN_LE_COUNT: assert property (values_updated
    |-> consecutive_interrupted_count <= interrupted_beam_count) else $error("run longer than count");
  AST_CENTRAL: assert property (values_updated && last_interrupted_beam != 8'hFF
    |-> central_interrupted_beam == 8'(({1'b0, first_interrupted_beam} + {1'b0, last_interrupted_beam}) >> 1))
    else $error("central beam not midway");
  COV_TEACH: cover property (fe_teach_start ##[1:20] !teach_busy);
  COV_ERR: cover property (resp_valid && resp_error);
  COV_OBJ: cover property (values_updated && interrupted_beam_count != 8'h00);
endmodule
bind btb_bank btb_bank_chk chk (.clock, .rst_b, .req_valid, .req_write, .req_index, .req_wdata, .resp_valid,
  .resp_error, .fe_teach_start, .teach_busy, .values_updated, .interrupted_beam_count, .first_interrupted_beam,
  .last_interrupted_beam, .consecutive_interrupted_count, .central_interrupted_beam);

// File: dv/btb_far_model.sv
// Fieldbus master and optical front end that face the beam parameter bank.
module btb_far_model
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Request and response
  output logic req_valid,
  output logic req_write,
  output logic [7:0] req_index,
  output logic [31:0] req_wdata,
  input wire logic resp_valid,
  input wire logic resp_error,
  input wire logic [31:0] resp_rdata,
  // Front end teach link
  input wire logic fe_teach_start,
  output logic fe_teach_done,
  output logic [7:0] fe_teach_status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] status = 8'h00;
  int starts = 0;
  initial
  begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_index = 8'h00;
    req_wdata = 32'h0;
    fe_teach_done = 1'b0;
    fe_teach_status = 8'h00;
  end
  // ==========================================================================
  // One request held over one edge; released lines show inverted values.
  task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] q, output logic e, output logic ok);
    @(negedge clock);
    req_valid = 1'b1;
    req_write = w;
    req_index = idx;
    req_wdata = d;
    @(negedge clock);
    ok = resp_valid;
    e = resp_error;
    q = resp_rdata;
    req_valid = 1'b0;
    req_write = ~w;
    req_index = ~idx;
    req_wdata = ~d;
  endtask
  // ==========================================================================
  // Front end: threshold teach finishes five cycles after the start pulse.
  always @(posedge clock)
    if (fe_teach_start)
    begin
      starts++;
      repeat (5) @(negedge clock);
      fe_teach_done = 1'b1;
      fe_teach_status = status;
      @(negedge clock);
      fe_teach_done = 1'b0;
      fe_teach_status = ~status;
    end
endmodule

// File: dv/tb.sv
// Self-checking bench for the beam parameter bank.
module tb;
  import btb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [NUM_BEAMS-1:0] beam_blocked = '0;
  logic fe_teach_needed_evt = 1'b0;
  logic req_valid, req_write, resp_valid, resp_error, fe_teach_start, fe_teach_done, teach_busy, values_updated;
  logic [7:0] req_index, fe_teach_status;
  logic [31:0] req_wdata, resp_rdata, rd;
  logic [7:0] interrupted_beam_count, clear_beam_count, first_interrupted_beam, first_clear_beam;
  logic [7:0] last_interrupted_beam, last_clear_beam, consecutive_interrupted_count, consecutive_clear_count;
  logic [7:0] central_interrupted_beam, central_clear_beam, object_outer_size, object_inner_size;
  logic er, ok;
  int fails = 0;
  int tests_run = 0;
  always #20 clock = ~clock;
  // ==========================================================================
  // Instances
  btb_bank dut (.clock, .rst_b, .beam_blocked, .req_valid, .req_write, .req_index, .req_wdata, .resp_valid,
    .resp_error, .resp_rdata, .fe_teach_start, .fe_teach_done, .fe_teach_status, .fe_teach_needed_evt, .teach_busy,
    .interrupted_beam_count, .clear_beam_count, .first_interrupted_beam, .first_clear_beam, .last_interrupted_beam,
    .last_clear_beam, .consecutive_interrupted_count, .consecutive_clear_count, .central_interrupted_beam,
    .central_clear_beam, .object_outer_size, .object_inner_size, .values_updated);
  btb_far_model far (.clock, .rst_b, .req_valid, .req_write, .req_index, .req_wdata, .resp_valid, .resp_error,
    .resp_rdata, .fe_teach_start, .fe_teach_done, .fe_teach_status);
  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic exp_err);
    far.acc(w, idx, d, rd, er, ok);
    check("resp_valid", 1'b1, ok);
    check("resp_error", exp_err, er);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0, 1'b0);
    check("resp_rdata", exp, rd);
  endtask
  task automatic teach();
    xfer(1'b1, IDX_TEACH_START, 32'h0, 1'b0);
    xfer(1'b1, IDX_TEACH_START, 32'h1, 1'b0);
    for (int i = 0; i < 40 && teach_busy !== 1'b0; i++) @(negedge clock);
    check("teach_busy", 1'b0, teach_busy);
  endtask
  task automatic two_passes();
    for (int p = 0; p < 2; p++)
    begin
      @(negedge clock);
      for (int i = 0; i < 600 && values_updated !== 1'b1; i++) @(negedge clock);
      check("values_updated", 1'b1, values_updated);
    end
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset_refuse();
    rd_chk(IDX_TEACH_NEEDED, 32'h1);
    rd_chk(IDX_TEACH_OUTCOME, 32'h0);
    rd_chk(IDX_MASK_LAST, 32'hFFFFFFFF);
    xfer(1'b1, IDX_TEACH_OUTCOME, 32'h1, 1'b1);
    xfer(1'b1, IDX_MASK_FIRST, 32'h0, 1'b1);
    xfer(1'b0, 8'h56, 32'h0, 1'b1);
  endtask
  task automatic t_teach();
    far.status = 8'hA5;
    teach();
    check("starts", 1, far.starts);
    rd_chk(IDX_TEACH_OUTCOME, 32'hA5);
    rd_chk(IDX_TEACH_NEEDED, 32'h1);
    xfer(1'b1, IDX_TEACH_START, 32'h1, 1'b0);
    repeat (10) @(negedge clock);
    check("starts", 1, far.starts);
    far.status = 8'h00;
    teach();
    check("starts", 2, far.starts);
    rd_chk(IDX_TEACH_NEEDED, 32'h0);
    fe_teach_needed_evt = 1'b1;
    @(negedge clock);
    fe_teach_needed_evt = 1'b0;
    rd_chk(IDX_TEACH_NEEDED, 32'h1);
  endtask
  task automatic t_blank();
    beam_blocked = '0;
    beam_blocked[0] = 1'b1;
    beam_blocked[1] = 1'b1;
    beam_blocked[39] = 1'b1;
    xfer(1'b1, IDX_EXCL_INTERRUPTED, 32'h1, 1'b0);
    rd_chk(IDX_MASK_FIRST, 32'hFFFFFFFC);
    rd_chk(8'h47, 32'hFFFFFF7F);
    beam_blocked = '0;
    beam_blocked[4:2] = 3'h7;
    two_passes();
    check("interrupted_count", 8'h03, interrupted_beam_count);
    check("clear_count", 8'hFF, clear_beam_count);
    check("first_interrupted", 8'h03, first_interrupted_beam);
    check("first_clear", 8'h06, first_clear_beam);
    check("last_interrupted", 8'h05, last_interrupted_beam);
    check("last_clear", 8'hFF, last_clear_beam);
    check("consecutive_clear", 8'hFF, consecutive_clear_count);
    check("central_clear", 8'hFF, central_clear_beam);
    check("consecutive_interrupted", 8'h03, consecutive_interrupted_count);
    check("central_interrupted", 8'h04, central_interrupted_beam);
    check("outer_size", 8'h03, object_outer_size);
    check("inner_size", 8'h00, object_inner_size);
    xfer(1'b1, IDX_EXCL_CLEAR, 32'h1, 1'b0);
    rd_chk(IDX_MASK_FIRST, 32'h0000001C);
    rd_chk(8'h47, 32'h0);
  endtask
  task automatic t_restore();
    beam_blocked = '0;
    beam_blocked[0] = 1'b1;
    xfer(1'b1, IDX_TEACH_WITH_EXCL, 32'h1, 1'b0);
    rd_chk(IDX_TEACH_WITH_EXCL, 32'h1);
    teach();
    rd_chk(IDX_MASK_FIRST, 32'hFFFFFFFE);
    beam_blocked = '0;
    xfer(1'b1, IDX_EXCL_INTERRUPTED, 32'h0, 1'b0);
    xfer(1'b1, IDX_EXCL_INTERRUPTED, 32'h1, 1'b0);
    teach();
    rd_chk(IDX_MASK_FIRST, 32'hFFFFFFFF);
  endtask
  // ==========================================================================
  // Sequence, watchdog and verdict
  task automatic print_verdict();
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    t_reset_refuse();
    t_teach();
    t_blank();
    t_restore();
    print_verdict();
  end
  initial
  begin
    #1000000;
    fails++;
    print_verdict();
  end
endmodule
